// *** rtl/prx_pkg.sv ***
/*
 * shared constants and carrier types for the peripheral set/clear register window.
 * assumes a 32-bit peripheral bus with byte strobes, one clock and an async reset.
 */
package prx_pkg;

   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam logic [31:0] PRX_PERIPH_BASE = 32'hffd0_0000;   // start of top 3 Mbyte
   localparam int PRX_REGION_BITS = 14;                       // 16 Kbyte per peripheral
   localparam logic [31:0] PRX_INTC_BASE = 32'hffff_f000;     // 4 Kbyte interrupt controller
   localparam int PRX_INTC_BITS = 12;
   localparam int PRX_MAX_PERIPH = 191;                       // last 16 Kbyte holds the intc

   // ----------------------------------------------------------------
   // register offsets inside one region
   // ----------------------------------------------------------------
   localparam logic [13:0] PRX_OFF_SET = 14'h0000;
   localparam logic [13:0] PRX_OFF_CLR = 14'h0004;
   localparam logic [13:0] PRX_OFF_STAT = 14'h0008;
   localparam logic [31:0] PRX_REG_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } prx_apb_req_type;

   typedef struct packed {
      logic ready;
      logic slvErr;
      logic [31:0] rdata;
   } prx_win_state_type;

endpackage : prx_pkg

// *** rtl/prx_sc_reg.sv ***
/*
 * one set/clear register: written ones set or clear bits, zeros leave them.
 * assumes strobes are one-cycle pulses and never both high together.
 */
`timescale 1ns/100ps
`default_nettype none
module prx_sc_reg
   import prx_pkg::*;
#(
   parameter int WIDTH = 32
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic setStrobe,
   input wire logic clrStrobe,
   input wire logic [WIDTH-1:0] wrBits,
   output logic [WIDTH-1:0] value
);

   typedef struct packed {
      logic [WIDTH-1:0] bits;
   } prx_sc_state_type;

   prx_sc_state_type state_ff;
   prx_sc_state_type nxt_state;

   // ----------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      if (setStrobe)
      begin
         nxt_state.bits = state_ff.bits | wrBits;   // see [RULE2] see [RULE4]
      end
      else if (clrStrobe)
      begin
         nxt_state.bits = state_ff.bits & ~wrBits;  // see [RULE3] see [RULE4]
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff.bits <= WIDTH'(PRX_REG_RESET);     // see [RULE11]
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign value = state_ff.bits;

endmodule : prx_sc_reg
`default_nettype wire

// *** rtl/prx_window.sv ***
/*
 * peripheral-bus register window: region decode plus set/clear/read aliases.
 * assumes a bus bridge master using setup then access phases, one clock.
 */
// Functional notes
// [RULE1] each frequent register has a set, a clear and a read address
// [RULE2] ones written at the set address set those bits
// [RULE3] ones written at the clear address clear those bits
// [RULE4] zeros written at set or clear addresses change nothing
// [RULE5] the read address returns the stored value after earlier writes
// [RULE6] each peripheral gets 16 Kbyte inside the top 3 Mbyte
// [RULE7] the interrupt controller gets only 4 Kbyte
// [RULE8] base is the lowest region address, offsets count upward
// [RULE9] registers are reached only as peripheral-bus transfers from the bridge
// [RULE10] byte lanes are little-endian, lane 0 is bits 7 to 0
// [RULE11] registers reset to zero, empty offsets in a region read zero
`timescale 1ns/100ps
`default_nettype none
module prx_window
   import prx_pkg::*;
#(
   parameter int NUM_PERIPH = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire prx_apb_req_type busReq,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic [NUM_PERIPH:0][31:0] regValue
);

   localparam int NREG = NUM_PERIPH + 1;   // last index is the interrupt controller
   localparam int IW = $clog2(NREG);

   prx_win_state_type state_ff;
   prx_win_state_type nxt_state;
   logic reqSetup;
   logic reqAccess;
   logic isPeriph;
   logic isIntc;
   logic hit;
   logic [17:0] regionNum;
   logic [IW-1:0] hitIdx;
   logic [13:0] offs;
   logic [31:0] wrMask;
   logic [NREG-1:0] setWe;
   logic [NREG-1:0] clrWe;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   always_comb
   begin
      reqSetup = busReq.psel & ~busReq.penable;                 // see [RULE9]
      reqAccess = busReq.psel & busReq.penable & state_ff.ready;
      regionNum = busReq.paddr[31:PRX_REGION_BITS] - PRX_PERIPH_BASE[31:PRX_REGION_BITS];
      isIntc = busReq.paddr[31:PRX_INTC_BITS] == PRX_INTC_BASE[31:PRX_INTC_BITS];  // see [RULE7]
      isPeriph = (busReq.paddr[31:PRX_REGION_BITS] >= PRX_PERIPH_BASE[31:PRX_REGION_BITS])
                 && (regionNum < 18'(NUM_PERIPH));               // see [RULE6]
      hit = isIntc | isPeriph;
      hitIdx = isIntc ? IW'(NUM_PERIPH) : regionNum[IW-1:0];
      // offset from the lowest region address
      offs = isIntc ? {2'h0, busReq.paddr[11:0]} : busReq.paddr[13:0];  // see [RULE8]
      for (int b = 0; b < 4; b++)
      begin
         wrMask[8*b +: 8] = {8{busReq.pstrb[b]}};                // see [RULE10]
      end
      // every low address bit compares, so misaligned addresses miss every alias
      for (int i = 0; i < NREG; i++)
      begin
         // three aliases of one stored register
         setWe[i] = reqAccess & busReq.pwrite & hit & (hitIdx == IW'(i)) & (offs == PRX_OFF_SET);  // see [RULE1]
         clrWe[i] = reqAccess & busReq.pwrite & hit & (hitIdx == IW'(i)) & (offs == PRX_OFF_CLR);  // see [RULE1]
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // one stored register per region keeps the map small
   generate
      for (genvar g = 0; g < NREG; g++)
      begin : gReg
         prx_sc_reg #(.WIDTH(32)) uReg (
            .clk(clk),
            .rst(rst),
            .setStrobe(setWe[g]),
            .clrStrobe(clrWe[g]),
            .wrBits(busReq.pwdata & wrMask),
            .value(regValue[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_state = '0;   // see [RULE11]
      if (reqSetup)
      begin
         // zero-wait answer: ready rises for the access phase only
         // registered answer keeps every output on a flop at no wait-state cost
         nxt_state.ready = 1'b1;
         nxt_state.slvErr = ~hit;
         if (!busReq.pwrite && hit && offs == PRX_OFF_STAT)
         begin
            nxt_state.rdata = regValue[hitIdx];                 // see [RULE5]
         end
         // empty offsets fall through as zero
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign pready = state_ff.ready;
   assign pslverr = state_ff.slvErr;
   assign prdata = state_ff.rdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_set_bits: assert property (@(posedge clk) disable iff (rst) // see [RULE2]
      setWe[0] |=> regValue[0] == ($past(regValue[0]) | $past(busReq.pwdata & wrMask)))
      else $error("set alias did not set written ones");

   a_clear_bits: assert property (@(posedge clk) disable iff (rst) // see [RULE3]
      clrWe[0] |=> regValue[0] == ($past(regValue[0]) & ~$past(busReq.pwdata & wrMask)))
      else $error("clear alias did not clear written ones");

   a_zero_no_effect: assert property (@(posedge clk) disable iff (rst) // see [RULE4]
      (setWe[0] && busReq.pwdata == 32'h0000_0000) |=> $stable(regValue[0]))
      else $error("writing zeros changed the register");

   a_intc_read: assert property (@(posedge clk) disable iff (rst) // see [RULE5]
      (reqSetup && !busReq.pwrite && busReq.paddr == (PRX_INTC_BASE | 32'(PRX_OFF_STAT)))
      |=> pready && !pslverr && prdata == regValue[NUM_PERIPH])
      else $error("read alias did not return stored value");

   a_region_size: assert property (@(posedge clk) disable iff (rst) // see [RULE6]
      (reqSetup && busReq.paddr[31:14] == PRX_PERIPH_BASE[31:14] && busReq.paddr[13:0] == 14'h3ffc)
      |=> pready && !pslverr && prdata == 32'h0000_0000)
      else $error("end of 16 Kbyte region not decoded");

   a_intc_size: assert property (@(posedge clk) disable iff (rst) // see [RULE7]
      (reqSetup && busReq.paddr[31:12] == 20'hffffe) |=> pready && pslverr)
      else $error("interrupt controller region wider than 4 Kbyte");

   a_base_read: assert property (@(posedge clk) disable iff (rst) // see [RULE8]
      (reqSetup && !busReq.pwrite && busReq.paddr == (PRX_PERIPH_BASE | 32'(PRX_OFF_STAT)))
      |=> prdata == regValue[0])
       else $error("offset not counted from region base");

   a_one_cycle_ready: assert property (@(posedge clk) disable iff (rst) // see [RULE9]
      pready |=> !pready)
      else $error("ready held beyond the access phase");

   a_lane_order: assert property (@(posedge clk) disable iff (rst) // see [RULE10]
      (setWe[0] && busReq.pstrb == 4'h1) |=> regValue[0][31:8] == $past(regValue[0][31:8]))
      else $error("byte lane 0 wrote upper bits");

   a_empty_zero: assert property (@(posedge clk) disable iff (rst) // see [RULE11]
      (reqSetup && !busReq.pwrite && hit && offs > PRX_OFF_STAT) |=> prdata == 32'h0000_0000)
      else $error("empty offset did not read zero");

   a_clear_zero: assert property (@(posedge clk) disable iff (rst) // see [RULE4]
      (clrWe[0] && busReq.pwdata == 32'h0000_0000) |=> $stable(regValue[0]))
      else $error("clearing with zeros changed the register");

   a_read_alias_ro: assert property (@(posedge clk) disable iff (rst) // see [RULE1]
      (reqAccess && busReq.pwrite && hit && offs == PRX_OFF_STAT) |=> $stable(regValue))
      else $error("write to read alias changed a register");

   a_miss_no_write: assert property (@(posedge clk) disable iff (rst) // see [RULE6]
      (reqAccess && busReq.pwrite && !hit) |=> $stable(regValue))
      else $error("write outside every region changed a register");

   a_miss_error: assert property (@(posedge clk) disable iff (rst) // see [RULE6]
      (reqSetup && !hit) |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("address outside every region not refused");

   a_intc_set: assert property (@(posedge clk) disable iff (rst) // see [RULE7]
      setWe[NUM_PERIPH]
      |=> regValue[NUM_PERIPH] == ($past(regValue[NUM_PERIPH]) | $past(busReq.pwdata & wrMask)))
      else $error("interrupt controller set alias failed");

   a_intc_clear: assert property (@(posedge clk) disable iff (rst) // see [RULE3]
      clrWe[NUM_PERIPH]
      |=> regValue[NUM_PERIPH] == ($past(regValue[NUM_PERIPH]) & ~$past(busReq.pwdata & wrMask)))
      else $error("interrupt controller clear alias failed");

   a_ready_follows: assert property (@(posedge clk) disable iff (rst) // see [RULE9]
      reqSetup |=> pready)
      else $error("setup phase not answered in the next cycle");

   a_lane_upper: assert property (@(posedge clk) disable iff (rst) // see [RULE10]
      (setWe[1] && busReq.pstrb == 4'h2)
      |=> regValue[1][7:0] == $past(regValue[1][7:0]) && regValue[1][31:16] == $past(regValue[1][31:16]))
      else $error("byte lane 1 wrote other lanes");

   a_read_no_error: assert property (@(posedge clk) disable iff (rst) // see [RULE5]
      (reqSetup && !busReq.pwrite && hit) |=> pready && !pslverr)
      else $error("read inside a region refused");

   a_one_target: assert property (@(posedge clk) disable iff (rst) // see [RULE8]
      setWe[0] |=> regValue[NUM_PERIPH:1] == $past(regValue[NUM_PERIPH:1]))
      else $error("write to region 0 reached another register");

   a_empty_no_write: assert property (@(posedge clk) disable iff (rst) // see [RULE11]
      (reqAccess && busReq.pwrite && hit && offs > PRX_OFF_STAT) |=> $stable(regValue))
      else $error("write to empty offset changed a register");

endmodule : prx_window
`default_nettype wire

// *** sim/prx_bridge_model.sv ***
/*
 bus bridge model: drives setup then access phases into the register window.
 assumes one caller at a time and a single rising-edge clock.
*/
`timescale 1ns/100ps
`default_nettype none
module prx_bridge_model
   import prx_pkg::*;
(
   input wire logic clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output var prx_apb_req_type busReq
);
   // ----------------------------------------
   // transfer
   // ----------------------------------------
   int unanswered = 0;
   initial busReq = '0;
   // bounded wait so a dead slave cannot hang the caller
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
      input logic [3:0] strb, output logic [31:0] rd, output logic err);
      int n;
      begin
         n = 0;
         @(negedge clk);
         busReq.psel = 1'b1;
         busReq.penable = 1'b0;
         busReq.pwrite = wr;
         busReq.paddr = addr;
         busReq.pwdata = wd;
         busReq.pstrb = strb;
         @(negedge clk);
         busReq.penable = 1'b1;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (pready !== 1'b1 && n < 8);
         if (pready !== 1'b1)
         begin
            unanswered++;
         end
         rd = prdata;
         err = pslverr;
         @(negedge clk);
         // released address and data lines show garbage, not the last value
         busReq.psel = 1'b0;
         busReq.penable = 1'b0;
         busReq.paddr = ~addr;
         busReq.pwdata = ~wd;
      end
   endtask : xfer
endmodule : prx_bridge_model
`default_nettype wire

// *** sim/testbench.sv ***
/*
 self-checking bench for the set/clear register window.
 assumes the bridge model as bus master and a 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
   import prx_pkg::*;
;
   localparam int NP = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   prx_apb_req_type busReq;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic [NP:0][31:0] regValue;
   logic [31:0] rd;
   logic er;
   int fails = 0;
   int total_checks = 0;
   always #10 clk = ~clk;
   prx_window #(.NUM_PERIPH(NP)) DUT (.clk(clk), .rst(rst), .busReq(busReq), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .regValue(regValue));
   prx_bridge_model bridge (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .busReq(busReq));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk
   function automatic logic [31:0] base(input int k);
      return PRX_PERIPH_BASE + 32'(k) * 32'h0000_4000;
   endfunction : base
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      for (int k = 0; k <= NP; k++)
         chk("reset value", 32'h0, regValue[k]);
      bridge.xfer(1'b0, base(0) + 32'h8, 32'h0, 4'hf, rd, er);
      chk("reset read", 32'h0, rd);
   endtask : test_reset
   task automatic test_alias(input logic [31:0] b, input int k);
      bridge.xfer(1'b1, b, 32'h0000_00a5, 4'hf, rd, er);
      bridge.xfer(1'b0, b + 32'h8, 32'h0, 4'hf, rd, er);
      chk("read after set", 32'h0000_00a5, rd);
      bridge.xfer(1'b1, b, 32'h0, 4'hf, rd, er);
      bridge.xfer(1'b1, b + 32'h4, 32'h0, 4'hf, rd, er);
      chk("zero writes", 32'h0000_00a5, regValue[k]);
      bridge.xfer(1'b1, b, 32'h0f00_0000, 4'hf, rd, er);
      bridge.xfer(1'b1, b + 32'h4, 32'h0000_0081, 4'hf, rd, er);
      bridge.xfer(1'b1, b + 32'hc, 32'hffff_ffff, 4'hf, rd, er);
      chk("empty offset write error", 32'h0, 32'(er));
      bridge.xfer(1'b0, b + 32'h8, 32'h0, 4'hf, rd, er);
      chk("read after clear", 32'h0f00_0024, rd);
      chk("stored value", 32'h0f00_0024, regValue[k]);
      bridge.xfer(1'b0, b + 32'hc, 32'h0, 4'hf, rd, er);
      chk("empty offset", 32'h0, rd);
      chk("empty offset error", 32'h0, 32'(er));
   endtask : test_alias
   task automatic test_lanes();
      bridge.xfer(1'b1, base(1), 32'hffff_ffff, 4'b0010, rd, er);
      chk("lane set", 32'h0000_ff00, regValue[1]);
      bridge.xfer(1'b1, base(0), 32'hffff_ffff, 4'b0001, rd, er);
      chk("lane 0 set", 32'h0f00_00ff, regValue[0]);
      bridge.xfer(1'b1, base(0) + 32'h4, 32'hffff_ffff, 4'b1000, rd, er);
      chk("lane 3 clear", 32'h0000_00ff, regValue[0]);
      bridge.xfer(1'b1, base(1) + 32'h8, 32'hffff_ffff, 4'hf, rd, er);
      chk("read alias write", 32'h0000_ff00, regValue[1]);
   endtask : test_lanes
   task automatic test_midreset();
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      for (int k = 0; k <= NP; k++)
         chk("mid-run reset value", 32'h0, regValue[k]);
      chk("ready in reset", 32'h0, 32'(pready));
      rst = 1'b0;
      bridge.xfer(1'b0, base(1) + 32'h8, 32'h0, 4'hf, rd, er);
      chk("read after mid-run reset", 32'h0, rd);
   endtask : test_midreset
   task automatic test_decode();
      bridge.xfer(1'b1, base(NP), 32'hffff_ffff, 4'hf, rd, er);
      chk("past last region", 32'h1, 32'(er));
      bridge.xfer(1'b0, base(0) - 32'h4, 32'h0, 4'hf, rd, er);
      chk("below top area", 32'h1, 32'(er));
      chk("error data", 32'h0, rd);
      bridge.xfer(1'b0, base(0) + 32'h3ffc, 32'h0, 4'hf, rd, er);
      chk("region end error", 32'h0, 32'(er));
      bridge.xfer(1'b0, PRX_INTC_BASE + 32'hffc, 32'h0, 4'hf, rd, er);
      chk("intc end error", 32'h0, 32'(er));
      bridge.xfer(1'b0, PRX_INTC_BASE - 32'h1000, 32'h0, 4'hf, rd, er);
      chk("below intc", 32'h1, 32'(er));
   endtask : test_decode
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      test_reset();
      test_alias(base(0), 0);
      test_alias(base(NP - 1), NP - 1);
      test_alias(PRX_INTC_BASE, NP);
      test_lanes();
      test_midreset();
      test_decode();
      chk("unanswered transfers", 32'h0, 32'(bridge.unanswered));
      print_verdict();
   end
   // about 140 cycles of traffic; far more margin than needed
   initial
   begin
      #40000;
      fails++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
